// ---- rtl/phs_consts.vh ----
// phs_consts.vh: register offsets, field positions, reset values, timing counts
// assumes: included by the command/status block, 10 MHz system clock
`ifndef PHS_CONSTS_VH
`define PHS_CONSTS_VH
// register byte addresses
`define PHS_OFF_CTRL 8'h00
`define PHS_OFF_DEVCFG 8'h04
`define PHS_OFF_SMB 8'h08
`define PHS_OFF_STATUS_WORD 8'h0C
`define PHS_OFF_STATUS_IN 8'h10
`define PHS_OFF_STATUS_VOUT 8'h14
`define PHS_OFF_STATUS_IOUT 8'h18
`define PHS_OFF_STATUS_MFR 8'h1C
`define PHS_OFF_CAPABILITY 8'h20
`define PHS_OFF_INFO 8'h24
`define PHS_OFF_INFO_DATA 8'h28
// control register fields
`define PHS_CTRL_ON 0
`define PHS_CTRL_CLEAR 1
`define PHS_CTRL_CONVERT 2
`define PHS_CTRL_CYCLE 3
`define PHS_CTRL_GROUP 4
`define PHS_CTRL_PEC_BAD 5
`define PHS_CTRL_RST 32'h0000_0001
// device config fields
`define PHS_CFG_FOLDBACK 0
`define PHS_CFG_GLITCH_LO 1
`define PHS_CFG_GLITCH_HI 2
`define PHS_CFG_WARN2_POL 3
`define PHS_CFG_OPEN 4
`define PHS_CFG_RST 8'h01
// smb event register fields
`define PHS_SMB_STOP 0
`define PHS_SMB_ABORT 1
// status word fields
`define PHS_SB_OFF 6
`define PHS_SB_IOUT_OC 4
`define PHS_SB_VIN_UV 3
`define PHS_SB_CML 1
`define PHS_SW_VOUT 15
`define PHS_SW_IOUT 14
`define PHS_SW_INPUT 13
`define PHS_SW_MFR 12
`define PHS_SW_OPEN_BIT 11
// capability: 400 kHz speed code, pec supported, alert supported
`define PHS_CAPABILITY 8'hB0
// power cycle off time in ms, count of cycles at 10 MHz
`define PHS_CLK_HZ 10000000
`define PHS_CYCLE_MS 4000
`define PHS_CYCLE_CNT ((`PHS_CLK_HZ / 1000) * `PHS_CYCLE_MS)
`endif

// ---- rtl/phs_command_status.v ----
// phs_command_status.v: command layer and status tree of a hot-swap controller.
// assumes an AXI4-Lite master on sys_clk, a hot-swap state machine and a power
// monitor supplying levels from other clocks (all synchronised here).
// How it works
// [RULE_01] group writes only, own address, no reads
// [RULE_02] host chains repeated starts, one final stop
// [RULE_03] group command held until stop condition
// [RULE_04] group conversion starts at stop
// [RULE_05] on request ignored during undervoltage
// [RULE_06] on bit low forces gate low
// [RULE_07] on bit resets to one
// [RULE_08] operation refused until allow bit set
// [RULE_09] on bit zero turns gate off
// [RULE_10] on bit no effect during uv/ov
// [RULE_11] on bit off then on clears latches
// [RULE_12] output enabled readable in status byte/word
// [RULE_13] config holds foldback, glitch, warn2 polarity
// [RULE_14] power cycle: off four seconds, back on
// [RULE_15] capability gives speed, pec, alert
// [RULE_16] info strings block read with count
// [RULE_17] six status registers in hierarchy
// [RULE_18] word low byte equals status byte
// [RULE_19] faults only overcurrent timeout, ov, uv
// [RULE_20] every fault acts on gate
// [RULE_21] warnings never touch hot-swap control
// [RULE_22] faults latch until cleared, live bits track
// [RULE_23] clear while active sets again
// [RULE_24] bad pec write not executed, flag set
// [RULE_25] gate enable is and of four terms; code ands seven (on bit, uv, ov, permit, not cycling, oc timeout, oc latch)
// [RULE_26] aborted group command discarded
`timescale 1ns/10ps
`include "phs_consts.vh"
module phs_command_status #(
   parameter [31:0] cycle_cnt = `PHS_CYCLE_CNT
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire undervoltage_input,
   input wire overvoltage_input,
   input wire oc_timeout,
   input wire hs_permit,
   input wire [4:0] warn_in,
   input wire hw_convert_trigger,
   output reg gate_enable,
   output reg hw_convert_trigger_start,
   output reg foldback_en,
   output reg [1:0] glitch_sel,
   output reg warn2_polarity,
   output reg fault_any
);
   // external levels: two flops, only the second one is read
   reg [9:0] sync_a;
   reg [9:0] sync_b;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_a <= 10'h000;
         sync_b <= 10'h000;
      end else begin
         sync_a <= {hw_convert_trigger, warn_in, hs_permit, oc_timeout, overvoltage_input, undervoltage_input};
         sync_b <= sync_a;
      end
   end
   wire uv_ok = sync_b[0];
   wire ov_hi = sync_b[1];
   wire oc_to = sync_b[2];
   wire permit = sync_b[3];
   wire [4:0] warn = sync_b[8:4];
   wire hw_convert_trigger_pin = sync_b[9];
   reg hw_convert_trigger_pin_d;

   // bus handshake: address and data may come in either order
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
   wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
   wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
   wire wr_fire = have_aw && have_w && !s_axi_bvalid;
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   wire rd_info_data = rd_fire && (s_axi_araddr == `PHS_OFF_INFO_DATA);

   // registers
   reg on_bit;
   reg op_allow;
   reg pend_valid;
   reg pend_on;
   reg pend_hw_convert_trigger;
   reg pend_cycle;
   reg pend_clear;
   reg cml_flag;
   reg on_was_off;
   reg [31:0] cycle_timer;
   reg cycling;
   reg flt_uv;
   reg flt_ov;
   reg flt_oc;
   reg [4:0] warn_l;
   reg [1:0] info_sel;
   reg [4:0] info_idx;

   wire wr_ctrl = wr_fire && (wa == `PHS_OFF_CTRL) && ws[0];
   wire wr_cfg = wr_fire && (wa == `PHS_OFF_DEVCFG) && ws[0];
   wire wr_smb = wr_fire && (wa == `PHS_OFF_SMB) && ws[0];
   wire wr_info = wr_fire && (wa == `PHS_OFF_INFO) && ws[0];
   wire pec_bad = wd[`PHS_CTRL_PEC_BAD];
   // [RULE_01] only writes defer
   wire is_group = wd[`PHS_CTRL_GROUP];
   // [RULE_08] refused before allowed
   wire op_refused = wr_ctrl && !op_allow;
   // [RULE_24] bad pec discarded
   wire ctrl_ok = wr_ctrl && op_allow && !pec_bad;
   wire exec_now = ctrl_ok && !is_group;
   // [RULE_03] held until stop
   wire stop_seen = wr_smb && wd[`PHS_SMB_STOP] && !wd[`PHS_SMB_ABORT];
   wire exec_pend = stop_seen && pend_valid;
   wire ex_any = exec_now || exec_pend;
   wire ex_on = exec_now ? wd[`PHS_CTRL_ON] : pend_on;
   wire ex_hw_convert_trigger = exec_now ? wd[`PHS_CTRL_CONVERT] : pend_hw_convert_trigger;
   wire ex_cycle = exec_now ? wd[`PHS_CTRL_CYCLE] : pend_cycle;
   wire ex_clear = exec_now ? wd[`PHS_CTRL_CLEAR] : pend_clear;
   // [RULE_11] off then on clears
   wire toggle_clear = ex_any && ex_on && !on_bit && on_was_off;
   wire clear_all = (ex_any && ex_clear) || toggle_clear;

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (op_refused || (wa > `PHS_OFF_INFO) || wa[1:0] != 2'b00) begin
               s_axi_bresp <= 2'b10;
            end else begin
               s_axi_bresp <= 2'b00;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // settings word; op_allow starts low so software cannot cut the gate by accident
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         op_allow <= 1'b0;
         foldback_en <= 1'b1;
         glitch_sel <= 2'b00;
         warn2_polarity <= 1'b0;
      end else begin
         // [RULE_13] config fields
         if (wr_cfg) begin
            foldback_en <= wd[`PHS_CFG_FOLDBACK];
            glitch_sel <= wd[`PHS_CFG_GLITCH_HI:`PHS_CFG_GLITCH_LO];
            warn2_polarity <= wd[`PHS_CFG_WARN2_POL];
            op_allow <= wd[`PHS_CFG_OPEN];
         end
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // [RULE_07] on bit reset one
         on_bit <= 1'b1;
         on_was_off <= 1'b0;
         pend_valid <= 1'b0;
         pend_on <= 1'b0;
         pend_hw_convert_trigger <= 1'b0;
         pend_cycle <= 1'b0;
         pend_clear <= 1'b0;
         cml_flag <= 1'b0;
         cycling <= 1'b0;
         cycle_timer <= 32'h0000_0000;
      end else begin
         // [RULE_03] buffer group write
         if (ctrl_ok && is_group) begin
            pend_valid <= 1'b1;
            pend_on <= wd[`PHS_CTRL_ON];
            pend_hw_convert_trigger <= wd[`PHS_CTRL_CONVERT];
            pend_cycle <= wd[`PHS_CTRL_CYCLE];
            pend_clear <= wd[`PHS_CTRL_CLEAR];
         end else if (wr_smb) begin
            // [RULE_26] abort drops pending
            pend_valid <= 1'b0;
         end
         if (ex_any) begin
            on_bit <= ex_on;
            if (!ex_on) begin
               on_was_off <= 1'b1;
            end else begin
               on_was_off <= 1'b0;
            end
         end
         // [RULE_24] error flag, set wins over clear
         if (wr_ctrl && op_allow && pec_bad) begin
            cml_flag <= 1'b1;
         end else if (clear_all) begin
            cml_flag <= 1'b0;
         end
         // [RULE_14] timed off then on
         if (ex_any && ex_cycle) begin
            cycling <= 1'b1;
            cycle_timer <= cycle_cnt;
         end else if (cycling) begin
            if (cycle_timer <= 32'h0000_0001) begin
               cycling <= 1'b0;
            end
            cycle_timer <= cycle_timer - 32'h0000_0001;
         end
      end
   end

   // edge found on the second sync flop only, so one pulse per rising pin edge
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hw_convert_trigger_start <= 1'b0;
         hw_convert_trigger_pin_d <= 1'b0;
      end else begin
         hw_convert_trigger_pin_d <= hw_convert_trigger_pin;
         // [RULE_04] convert on direct write, at stop, or on pin edge
         hw_convert_trigger_start <= (ex_any && ex_hw_convert_trigger) || (hw_convert_trigger_pin && !hw_convert_trigger_pin_d);
      end
   end

   // string pointer; a select write rewinds it to the count byte
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         info_sel <= 2'b00;
         info_idx <= 5'h00;
      end else begin
         if (wr_info) begin
            info_sel <= wd[1:0];
            info_idx <= 5'h00;
         end else if (rd_info_data) begin
            info_idx <= info_idx + 5'h01;
         end
      end
   end

   // [RULE_25] gate is and of terms
   // [RULE_05] [RULE_06] [RULE_09] [RULE_10] uv, ov and on bit gate it
   // raw timeout also cuts it, so overcurrent drops the gate as fast as uv and ov
   wire next_gate = on_bit && uv_ok && !ov_hi && permit && !cycling && !oc_to && !flt_oc;
   // [RULE_19] [RULE_22] [RULE_23] fault latches, condition wins over clear
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_uv <= 1'b0;
         flt_ov <= 1'b0;
         flt_oc <= 1'b0;
         warn_l <= 5'h00;
         gate_enable <= 1'b0;
         fault_any <= 1'b0;
      end else begin
         flt_uv <= !uv_ok || (flt_uv && !clear_all);
         flt_ov <= ov_hi || (flt_ov && !clear_all);
         flt_oc <= oc_to || (flt_oc && !clear_all);
         // [RULE_21] warnings latch only
         warn_l <= warn | (warn_l & {5{!clear_all}});
         // [RULE_20] fault drops gate
         gate_enable <= next_gate;
         fault_any <= flt_uv || flt_ov || flt_oc;
      end
   end

   // [RULE_17] six status views
   wire [7:0] st_input = {2'b00, flt_uv, 1'b0, warn_l[1], warn_l[0], flt_ov, 1'b0};
   wire [7:0] st_vout = {1'b0, warn_l[2], 1'b0, warn_l[3], 4'h0};
   wire [7:0] st_iout = {flt_oc, 1'b0, warn_l[4], 5'h00};
   wire [7:0] st_mfr = {4'h0, foldback_en, warn2_polarity, cycling, op_allow};
   // [RULE_12] off bit is live
   wire [7:0] st_byte = {1'b0, !gate_enable, 1'b0, flt_oc, flt_uv | flt_ov, 1'b0, cml_flag, 1'b0};
   // [RULE_18] word low equals byte
   wire [15:0] st_word = {|st_vout, |st_iout, |st_input, |st_mfr, 4'h0, st_byte};

   // [RULE_16] count then ascii text
   reg [7:0] info_byte;
   always @* begin
      info_byte = 8'h00;
      case (info_sel)
         2'b00: begin
            if (info_idx == 5'h00) info_byte = 8'h02;
            else if (info_idx == 5'h01) info_byte = 8'h48;
            else if (info_idx == 5'h02) info_byte = 8'h53;
         end
         2'b01: begin
            if (info_idx == 5'h00) info_byte = 8'h03;
            else if (info_idx == 5'h01) info_byte = 8'h48;
            else if (info_idx == 5'h02) info_byte = 8'h53;
            else if (info_idx == 5'h03) info_byte = 8'h43;
         end
         default: begin
            if (info_idx == 5'h00) info_byte = 8'h01;
            else if (info_idx == 5'h01) info_byte = 8'h41;
         end
      endcase
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         if (s_axi_araddr == `PHS_OFF_CTRL) begin
            s_axi_rdata <= {31'h0000_0000, on_bit};
         end else if (s_axi_araddr == `PHS_OFF_DEVCFG) begin
            s_axi_rdata <= {27'h000_0000, op_allow, warn2_polarity, glitch_sel, foldback_en};
         end else if (s_axi_araddr == `PHS_OFF_SMB) begin
            s_axi_rdata <= {31'h0000_0000, pend_valid};
         end else if (s_axi_araddr == `PHS_OFF_STATUS_WORD) begin
            s_axi_rdata <= {16'h0000, st_word};
         end else if (s_axi_araddr == `PHS_OFF_STATUS_IN) begin
            s_axi_rdata <= {24'h00_0000, st_input};
         end else if (s_axi_araddr == `PHS_OFF_STATUS_VOUT) begin
            s_axi_rdata <= {24'h00_0000, st_vout};
         end else if (s_axi_araddr == `PHS_OFF_STATUS_IOUT) begin
            s_axi_rdata <= {24'h00_0000, st_iout};
         end else if (s_axi_araddr == `PHS_OFF_STATUS_MFR) begin
            s_axi_rdata <= {24'h00_0000, st_mfr};
         end else if (s_axi_araddr == `PHS_OFF_CAPABILITY) begin
            // [RULE_15] capability byte
            s_axi_rdata <= {24'h00_0000, `PHS_CAPABILITY};
         end else if (s_axi_araddr == `PHS_OFF_INFO) begin
            s_axi_rdata <= {30'h0000_0000, info_sel};
         end else if (s_axi_araddr == `PHS_OFF_INFO_DATA) begin
            s_axi_rdata <= {24'h00_0000, info_byte};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // phs_command_status

// ---- tb/phs_asserts.sv ----
// phs_asserts.sv: port-level checks of the command/status block
// assumes: bound to phs_command_status, inputs synchronised inside it
`timescale 1ns/10ps
module phs_asserts (
   input wire sys_clk,
   input wire sys_rst,
   input wire s_axi_wvalid,
   input wire s_axi_bvalid,
   input wire s_axi_awready,
   input wire undervoltage_input,
   input wire overvoltage_input,
   input wire oc_timeout,
   input wire hs_permit,
   input wire hw_convert_trigger,
   input wire gate_enable,
   input wire hw_convert_trigger_start,
   input wire fault_any
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // four samples cover the two-flop sync and the gate register
   supply_low_off_a: assert property (!undervoltage_input [*4] |-> !gate_enable)
      else $error("gate on with supply low");
   overvolt_off_a: assert property (overvoltage_input [*4] |-> !gate_enable)
      else $error("gate on during overvoltage");
   permit_off_a: assert property (!hs_permit [*4] |-> !gate_enable)
      else $error("gate on without permit");
   oc_gate_off_a: assert property (oc_timeout [*4] |-> !gate_enable)
      else $error("gate on after overcurrent timeout");
   start_pulse_a: assert property (hw_convert_trigger_start |=> !hw_convert_trigger_start)
      else $error("start pulse longer than one cycle");
   trig_start_a: assert property ($rose(hw_convert_trigger) |-> ##[1:6] hw_convert_trigger_start)
      else $error("trigger edge gave no start");
   // a clear can only come from a write, so no write means no drop
   fault_hold_a: assert property (!s_axi_wvalid [*3] ##0 fault_any |=> fault_any)
      else $error("fault dropped without a write");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
   cover property (fault_any);
   cover property (hw_convert_trigger_start);
   cover property ($fell(gate_enable) && undervoltage_input);
endmodule // phs_asserts
bind phs_command_status phs_asserts phs_asserts_inst (.sys_clk, .sys_rst, .s_axi_wvalid, .s_axi_bvalid,
   .s_axi_awready, .undervoltage_input, .overvoltage_input, .oc_timeout, .hs_permit, .hw_convert_trigger,
   .gate_enable, .hw_convert_trigger_start, .fault_any);

// ---- tb/phs_host_model.sv ----
// phs_host_model.sv: bus host issuing register writes and reads
// assumes: handshakes judged at the rising edge, signals changed right after it
`timescale 1ns/10ps
`include "phs_consts.vh"
module phs_host_model (
   input wire sys_clk,
   output reg [7:0] s_axi_awaddr = 8'h00,
   output reg s_axi_awvalid = 1'b0,
   input wire s_axi_awready,
   output reg [31:0] s_axi_wdata = 32'h0000_0000,
   output wire [3:0] s_axi_wstrb,
   output reg s_axi_wvalid = 1'b0,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output wire s_axi_bready,
   output reg [7:0] s_axi_araddr = 8'h00,
   output reg s_axi_arvalid = 1'b0,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output wire s_axi_rready
);
   // response ready held high throughout
   assign s_axi_bready = 1'b1;
   assign s_axi_rready = 1'b1;
   assign s_axi_wstrb = 4'hF;
   task wr(input [7:0] a, input [31:0] d, output [1:0] r);
      reg da, dw;
      begin
         da = 1'b0;
         dw = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         // each channel drops its valid at the edge that takes it
         while (!(da && dw)) begin
            @(posedge sys_clk);
            if (!da && s_axi_awready === 1'b1) begin
               da = 1'b1;
               s_axi_awvalid <= 1'b0;
            end
            if (!dw && s_axi_wready === 1'b1) begin
               dw = 1'b1;
               s_axi_wvalid <= 1'b0;
            end
         end
         @(posedge sys_clk);
         while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
         r = s_axi_bresp;
      end
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         @(posedge sys_clk);
         while (s_axi_arready !== 1'b1) @(posedge sys_clk);
         s_axi_arvalid <= 1'b0;
         @(posedge sys_clk);
         while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
         d = s_axi_rdata;
         r = s_axi_rresp;
      end
   endtask
   task grp(input [31:0] c, input [31:0] ev);
      reg [1:0] r;
      begin
         wr(`PHS_OFF_CTRL, c, r);
         wr(`PHS_OFF_SMB, ev, r);
      end
   endtask
endmodule // phs_host_model

// ---- tb/tb_top.sv ----
// tb_top.sv: scenario bench for the command/status block
// assumes: host model owns the register bus, bench drives the levels
`timescale 1ns/10ps
`include "phs_consts.vh"
module tb_top;
   localparam integer CYC = 20;
   reg sys_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg undervoltage_input = 1'b1, overvoltage_input = 1'b0, oc_timeout = 1'b0, hs_permit = 1'b1;
   reg [4:0] warn_in = 5'h00;
   reg hw_convert_trigger = 1'b0;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp, glitch_sel;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   wire gate_enable, hw_convert_trigger_start, foldback_en, warn2_polarity, fault_any;
   integer n_errors = 0, num_checks = 0, cyc = 0, n_starts = 0, k, n, s;
   reg [1:0] rsp;
   reg [31:0] rdv;
   initial forever #50 sys_clk = ~sys_clk;
   phs_command_status #(.cycle_cnt(CYC)) phs_command_status_inst (.sys_clk, .sys_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .undervoltage_input, .overvoltage_input, .oc_timeout, .hs_permit, .warn_in,
      .hw_convert_trigger, .gate_enable, .hw_convert_trigger_start, .foldback_en, .glitch_sel, .warn2_polarity, .fault_any);
   phs_host_model phs_host_model_inst (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge sys_clk);
   endtask
   task w(input [7:0] a, input [31:0] d);
      phs_host_model_inst.wr(a, d, rsp);
   endtask
   task r(input [7:0] a);
      phs_host_model_inst.rd(a, rdv, rsp);
   endtask
   // inputs settle in three edges, six leaves margin
   task g(input e);
      begin
         tick(6);
         chk("gate", {31'h0, e}, {31'h0, gate_enable});
      end
   endtask
   task sb(input integer i, input e);
      begin
         r(`PHS_OFF_STATUS_WORD);
         chk("status", {31'h0, e}, {31'h0, rdv[i]});
      end
   endtask
   task t_boot;
      begin
         g(1);
         w(`PHS_OFF_CTRL, 32'h0000_0000);
         chk("bresp", 32'h2, {30'h0, rsp});
         g(1);
         w(`PHS_OFF_DEVCFG, 32'h0000_001F);
         chk("cfg", 32'hF, {28'h0, warn2_polarity, glitch_sel, foldback_en});
         w(`PHS_OFF_DEVCFG, 32'h0000_0012);
         chk("cfg", 32'h2, {28'h0, warn2_polarity, glitch_sel, foldback_en});
         w(`PHS_OFF_CTRL, 32'h0000_0000);
         g(0);
         sb(`PHS_SB_OFF, 1);
         w(`PHS_OFF_CTRL, 32'h0000_0001);
         g(1);
         sb(`PHS_SB_OFF, 0);
         hs_permit <= 1'b0;
         g(0);
         hs_permit <= 1'b1;
      end
   endtask
   task t_faults;
      begin
         undervoltage_input <= 1'b0;
         g(0);
         w(`PHS_OFF_CTRL, 32'h0000_0001);
         g(0);
         undervoltage_input <= 1'b1;
         sb(`PHS_SB_VIN_UV, 1);
         w(`PHS_OFF_CTRL, 32'h0000_0000);
         w(`PHS_OFF_CTRL, 32'h0000_0001);
         sb(`PHS_SB_VIN_UV, 0);
         overvoltage_input <= 1'b1;
         g(0);
         w(`PHS_OFF_CTRL, 32'h0000_0003);
         sb(`PHS_SB_VIN_UV, 1);
         overvoltage_input <= 1'b0;
         oc_timeout <= 1'b1;
         g(0);
         sb(`PHS_SB_IOUT_OC, 1);
         oc_timeout <= 1'b0;
         w(`PHS_OFF_CTRL, 32'h0000_0020);
         sb(`PHS_SB_CML, 1);
         r(`PHS_OFF_CTRL);
         chk("on_bit", 32'h1, rdv & 32'h1);
         tick(4);
         w(`PHS_OFF_CTRL, 32'h0000_0003);
         // the summary flag trails the latches by one edge
         tick(1);
         chk("fault_any", 32'h0, {31'h0, fault_any});
         sb(`PHS_SB_IOUT_OC, 0);
         g(1);
         warn_in <= 5'h10;
         g(1);
         r(`PHS_OFF_STATUS_WORD);
         chk("word", 32'h8, {28'h0, rdv[`PHS_SW_IOUT], rdv[6], rdv[4], rdv[3]});
         r(`PHS_OFF_STATUS_IOUT);
         chk("iout_set", 32'h1, {31'h0, rdv != 32'h0});
         warn_in <= 5'h00;
      end
   endtask
   task t_group;
      begin
         w(`PHS_OFF_CTRL, 32'h0000_0010);
         g(1);
         r(`PHS_OFF_SMB);
         chk("pending", 32'h1, rdv & 32'h1);
         w(`PHS_OFF_SMB, 32'h0000_0002);
         g(1);
         r(`PHS_OFF_SMB);
         chk("pending", 32'h0, rdv & 32'h1);
         phs_host_model_inst.grp(32'h0000_0010, 32'h0000_0001);
         g(0);
         k = n_starts;
         phs_host_model_inst.grp(32'h0000_0015, 32'h0000_0001);
         g(1);
         chk("starts", k + 1, n_starts);
         repeat (3) begin
            hw_convert_trigger <= 1'b1;
            tick(4);
            hw_convert_trigger <= 1'b0;
            tick(4);
         end
         chk("starts", k + 4, n_starts);
      end
   endtask
   task t_misc;
      begin
         w(`PHS_OFF_CTRL, 32'h0000_0009);
         k = 0;
         repeat (CYC + 40) begin
            @(posedge sys_clk);
            if (gate_enable === 1'b0) k = k + 1;
         end
         chk("cycle_off", CYC, k);
         g(1);
         r(`PHS_OFF_CAPABILITY);
         chk("cap", 32'hB0, rdv & 32'hFF);
         r(8'h30);
         chk("rresp", 32'h2, {30'h0, rsp});
         for (s = 0; s < 3; s = s + 1) begin
            w(`PHS_OFF_INFO, s);
            r(`PHS_OFF_INFO_DATA);
            n = rdv[7:0];
            chk("count", 32'h1, {31'h0, n > 0 && n < 64});
            repeat (n) begin
               r(`PHS_OFF_INFO_DATA);
               chk("ascii", 32'h1, {31'h0, rdv[7:0] >= 8'h20 && rdv[7:0] <= 8'h7E});
            end
         end
      end
   endtask
   always @(posedge sys_clk) if (hw_convert_trigger_start === 1'b1) n_starts <= n_starts + 1;
   // hang guard, run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors = n_errors + 1;
         final_report;
      end
   end
   initial begin
      tick(8);
      sys_rst <= 1'b0;
      tick(2);
      t_boot;
      t_faults;
      t_group;
      t_misc;
      final_report;
   end
endmodule // tb_top
